// ==== verilog/cpu_control_state.sv ====
// Purpose: Program counter, status word, stack pointer, register banks
//          and address-map classification of an 8-bit core.
// Assumes: Synchronous memory with one cycle of read latency.
// Notes:   Operation
`timescale 1ns/1ps
`default_nettype none
module cpu_control_state
  import cpu_state_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Core sequencing
  input  wire logic              pcAdvance,
  input  wire logic [2:0]        pcStep,
  input  wire logic              pcLoad,
  input  wire logic [15:0]       pcTarget,
  input  wire logic              fixedCall,
  input  wire logic [10:0]       fixedOffset,
  input  wire logic              tableCall,
  input  wire logic [4:0]        tableIndex,
  input  wire logic              aluUpdate,
  input  wire logic [7:0]        aluResult,
  input  wire logic              aluCarry,
  input  wire logic              aluHalfCarry,
  input  wire logic              carryWrite,
  input  wire logic              carryValue,
  input  wire logic              bankSelect,
  input  wire logic [1:0]        bankValue,
  input  wire logic              intDisable,
  input  wire logic              intEnable,
  input  wire logic              intRequest,
  input  wire logic              intLowLevel,
  input  wire logic              pswPush,
  input  wire logic              pswPop,
  input  wire logic [7:0]        popData,
  input  wire logic              regWrite,
  input  wire logic              regPair,
  input  wire logic [2:0]        regIndex,
  input  wire logic [15:0]       regWrData,
  input  wire logic [15:0]       probeAddr,
  input  wire logic [7:0]        memRdData,
  // Results
  output logic [15:0]            programCounter,
  output logic [7:0]             processorStatusWord,
  output logic [15:0]            stackPointer,
  output logic                   coreReady,
  output logic                   intAccept,
  output logic [15:0]            memAddr,
  output logic [7:0]             memWrData,
  output logic                   memWrite,
  output logic [15:0]            regRdData,
  output logic [6:0]             probeRegion
);

  // ----------------------------------------------------------------
  // Address classification
  // ----------------------------------------------------------------
  function automatic logic [6:0] classify(input logic [15:0] a);
    classify[0] = (a >= TCALL_LO) && (a <= TCALL_HI);
    classify[1] = (a == OPTION_ADDR);
    classify[2] = (a >= FCALL_LO) && (a <= FCALL_HI);
    classify[3] = (a >= RAM_LO) && (a <= RAM_HI);
    classify[4] = (a >= BANK_LO) && (a <= BANK_HI);
    classify[5] = (a >= SFR_LO);
    classify[6] = classify[3];
  endfunction

  // Bank 0 sits highest, so the byte index counts banks downward.
  function automatic logic [4:0] bankByte(input logic [1:0] b, input logic [2:0] r);
    bankByte = {~b, r};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  boot_t      boot;
  logic [7:0] vecLow;
  logic [7:0] bankFile [BANK_REGS*BANK_COUNT];
  logic       spValid;
  logic       spFault;
  logic       execFault;
  logic       awHeld;
  logic       wHeld;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0]  wStrbHeld;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        awTake   = awvalid && awready;
  wire        wTake    = wvalid && wready;
  wire        wrAddrOk = awHeld || awTake;
  wire        wrDataOk = wHeld || wTake;
  wire        wrFire   = wrAddrOk && wrDataOk && !bvalid;
  wire [ADDR_W-1:0] wrAddr = awHeld ? awAddrHeld : awaddr;
  wire [31:0] wrData   = wHeld ? wDataHeld : wdata;
  wire [3:0]  wrStrb   = wHeld ? wStrbHeld : wstrb;
  wire        wrPc     = wrFire && (wrAddr == REG_PC);
  wire        wrPsw    = wrFire && (wrAddr == REG_PSW);
  wire        wrSp     = wrFire && (wrAddr == REG_SP);
  wire        wrStatus = wrFire && (wrAddr == REG_STATUS);
  wire        wrBank   = wrFire && (wrAddr >= REG_BANK_BASE)
                         && (wrAddr <= REG_BANK_LAST) && (wrAddr[1:0] == 2'b00);
  wire        wrMapped = wrPc || wrPsw || wrSp || wrStatus || wrBank;
  wire [2:0]  wrWord   = wrAddr[4:2];
  wire        rdFire   = arvalid && arready;
  wire        rdBank   = (araddr >= REG_BANK_BASE) && (araddr <= REG_BANK_LAST)
                         && (araddr[1:0] == 2'b00);
  wire [2:0]  rdWord   = araddr[4:2];
  wire [31:0] bankWord = {bankFile[{rdWord, 2'd3}], bankFile[{rdWord, 2'd2}],
                          bankFile[{rdWord, 2'd1}], bankFile[{rdWord, 2'd0}]};
  wire [31:0] statusWord = {28'h0000000, execFault, spFault, spValid, coreReady};
  wire        rdMapped = (araddr == REG_PC) || (araddr == REG_PSW)
                         || (araddr == REG_SP) || (araddr == REG_STATUS) || rdBank;
  wire [31:0] rdValue  = (araddr == REG_PC)     ? {16'h0000, programCounter} :
                         (araddr == REG_PSW)    ? {24'h000000, processorStatusWord} :
                         (araddr == REG_SP)     ? {16'h0000, stackPointer} :
                         (araddr == REG_STATUS) ? statusWord :
                         rdBank                 ? bankWord : 32'h00000000;

  // ----------------------------------------------------------------
  // Core decode
  // ----------------------------------------------------------------
  wire        running   = (boot == RUN);
  wire [1:0]  bank      = {processorStatusWord[PSW_BANK_HI], processorStatusWord[PSW_BANK_LO]};
  wire        intOk     = processorStatusWord[PSW_IE]
                          && (processorStatusWord[PSW_ISP] || !intLowLevel);
  wire        accept    = running && intRequest && intOk;
  wire        doPush    = running && (pswPush || accept);
  wire        doPop     = running && pswPop && !doPush;
  wire [15:0] spDown    = stackPointer - SP_STEP;
  wire [15:0] spUp      = stackPointer + SP_STEP;
  wire [15:0] fixedDest = FCALL_LO | {5'b00000, fixedOffset};
  wire [15:0] tableSlot = TCALL_LO + {10'h000, tableIndex, 1'b0};
  wire [6:0]  targetCls = classify(pcTarget);
  wire        targetBad = targetCls[6];
  wire [15:0] pcStepped = programCounter + {13'h0000, pcStep};
  wire [4:0]  regLow    = bankByte(bank, {regIndex[2:1], 1'b0});
  wire [4:0]  regByte   = bankByte(bank, regIndex);
  wire [4:0]  bankBusWr = {wrWord, 2'b00};

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddrHeld <= '0;
      wDataHeld  <= 32'h00000000;
      wStrbHeld  <= 4'h0;
    end else begin
      if (awTake && !wrFire) begin
        awHeld     <= 1'b1;
        awAddrHeld <= awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (wTake && !wrFire) begin
        wHeld     <= 1'b1;
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h00000000;
    end else begin
      awready <= !awHeld && !awTake && !bvalid && !wrFire;
      wready  <= !wHeld && !wTake && !bvalid && !wrFire;
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= !rvalid && !rdFire;
      if (rdFire) begin
        rvalid <= 1'b1;
        rdata  <= rdValue;
        rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Boot sequence and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot           <= VEC_LO;
      vecLow         <= 8'h00;
      coreReady      <= 1'b0;
      programCounter <= RESET_VEC_LO;
      execFault      <= 1'b0;
    end else begin
      case (boot)
        VEC_LO: begin
          boot <= VEC_HI;
        end
        VEC_HI: begin
          vecLow <= memRdData;
          boot   <= VEC_LOAD;
        end
        VEC_LOAD: begin
          programCounter <= {memRdData, vecLow};
          coreReady      <= 1'b1;
          boot           <= RUN;
        end
        RUN: begin
          if (wrPc && wrStrb[0] && wrStrb[1]) begin
            programCounter <= wrData[15:0];
          end else if (fixedCall) begin
            programCounter <= fixedDest;
          end else if (pcLoad && !targetBad) begin
            programCounter <= pcTarget;
          end else if (pcAdvance) begin
            programCounter <= pcStepped;
          end
          // Hardware raising the fault outranks a software clear.
          if (pcLoad && !fixedCall && targetBad) begin
            execFault <= 1'b1;
          end else if (wrStatus && wrStrb[0] && wrData[ST_EXEC_FAULT]) begin
            execFault <= 1'b0;
          end
        end
        default: begin
          boot <= VEC_LO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status word, stack pointer and memory port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      processorStatusWord <= PSW_RESET;
      intAccept           <= 1'b0;
    end else begin
      intAccept <= accept;
      if (wrPsw && wrStrb[0]) begin
        processorStatusWord <= wrData[7:0];
      end else if (doPop) begin
        processorStatusWord <= popData;
      end else if (running) begin
        if (accept || intDisable) begin
          processorStatusWord[PSW_IE] <= 1'b0;
        end else if (intEnable) begin
          processorStatusWord[PSW_IE] <= 1'b1;
        end
        if (aluUpdate) begin
          processorStatusWord[PSW_Z]  <= (aluResult == 8'h00);
          processorStatusWord[PSW_AC] <= aluHalfCarry;
          processorStatusWord[PSW_CY] <= aluCarry;
        end else if (carryWrite) begin
          processorStatusWord[PSW_CY] <= carryValue;
        end
        if (bankSelect) begin
          processorStatusWord[PSW_BANK_HI] <= bankValue[1];
          processorStatusWord[PSW_BANK_LO] <= bankValue[0];
        end
      end
    end
  end

  // The pointer has no meaningful reset content; spValid tells software
  // whether it was loaded, and any stack use before that is flagged.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stackPointer <= 16'h0000;
      spValid      <= 1'b0;
      spFault      <= 1'b0;
      memAddr      <= RESET_VEC_LO;
      memWrData    <= 8'h00;
      memWrite     <= 1'b0;
    end else begin
      memWrite <= doPush;
      if (wrSp && wrStrb[0] && wrStrb[1]) begin
        stackPointer <= wrData[15:0];
        spValid      <= 1'b1;
      end else if (doPush) begin
        stackPointer <= spDown;
      end else if (doPop) begin
        stackPointer <= spUp;
      end
      if ((doPush || doPop) && !spValid) begin
        spFault <= 1'b1;
      end else if (wrStatus && wrStrb[0] && wrData[ST_SP_FAULT]) begin
        spFault <= 1'b0;
      end
      if (boot == VEC_LO) begin
        memAddr <= RESET_VEC_HI;
      end else if (doPush) begin
        memAddr   <= spDown;
        memWrData <= processorStatusWord;
      end else if (tableCall && running) begin
        memAddr <= tableSlot;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register banks and address probe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BANK_REGS*BANK_COUNT; i++) begin
        bankFile[i] <= 8'h00;
      end
      regRdData   <= 16'h0000;
      probeRegion <= 7'h00;
    end else begin
      probeRegion <= classify(probeAddr);
      if (wrBank) begin
        for (int k = 0; k < 4; k++) begin
          if (wrStrb[k]) begin
            bankFile[bankBusWr + 5'(k)] <= wrData[8*k +: 8];
          end
        end
      end else if (regWrite && running) begin
        if (regPair) begin
          bankFile[regLow]         <= regWrData[7:0];
          bankFile[regLow + 5'd1]  <= regWrData[15:8];
        end else begin
          bankFile[regByte] <= regWrData[7:0];
        end
      end
      regRdData <= regPair ? {bankFile[regLow + 5'd1], bankFile[regLow]}
                           : {8'h00, bankFile[regByte]};
    end
  end

endmodule
`default_nettype wire

// ==== pkg/cpu_state_pkg.sv ====
// Purpose: Shared constants for the processor control state block.
// Assumes: 8-bit core, 16-bit address space, AXI4-Lite register access.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package cpu_state_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_VEC_LO  = 16'h0000;
  localparam logic [15:0] RESET_VEC_HI  = 16'h0001;
  localparam logic [15:0] TCALL_LO      = 16'h0040;
  localparam logic [15:0] TCALL_HI      = 16'h007f;
  localparam logic [15:0] OPTION_ADDR   = 16'h0080;
  localparam logic [15:0] FCALL_LO      = 16'h0800;
  localparam logic [15:0] FCALL_HI      = 16'h0fff;
  localparam logic [15:0] RAM_LO        = 16'hfc00;
  localparam logic [15:0] RAM_HI        = 16'hfeff;
  localparam logic [15:0] BANK_LO       = 16'hfee0;
  localparam logic [15:0] BANK_HI       = 16'hfeff;
  localparam logic [15:0] SFR_LO        = 16'hff00;
  localparam logic [15:0] PC_STEP_UNIT  = 16'h0001;
  localparam logic [15:0] SP_STEP       = 16'h0001;
  localparam int          BANK_REGS     = 8;
  localparam int          BANK_COUNT    = 4;
  // ----------------------------------------------------------------
  // Status word layout and reset value
  // ----------------------------------------------------------------
  localparam int          PSW_IE        = 7;
  localparam int          PSW_Z         = 6;
  localparam int          PSW_BANK_HI   = 5;
  localparam int          PSW_AC        = 4;
  localparam int          PSW_BANK_LO   = 3;
  localparam int          PSW_ISP       = 1;
  localparam int          PSW_CY        = 0;
  localparam logic [7:0]  PSW_RESET     = 8'h02;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_PC        = 8'h00;
  localparam logic [7:0]  REG_PSW       = 8'h04;
  localparam logic [7:0]  REG_SP        = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0c;
  localparam logic [7:0]  REG_BANK_BASE = 8'h20;
  localparam logic [7:0]  REG_BANK_LAST = 8'h3c;
  localparam int          ST_READY      = 0;
  localparam int          ST_SP_VALID   = 1;
  localparam int          ST_SP_FAULT   = 2;
  localparam int          ST_EXEC_FAULT = 3;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef enum logic [1:0] {VEC_LO, VEC_HI, VEC_LOAD, RUN} boot_t;
endpackage

// ==== test/cpu_state_monitor.sv ====
// Purpose: Port checks for the control state block.
// Assumes: Register writes never coincide with core strobes.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module cpu_state_monitor
  import cpu_state_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        awvalid,
  input wire logic        wvalid,
  input wire logic        coreReady,
  input wire logic        pcAdvance,
  input wire logic [2:0]  pcStep,
  input wire logic        pcLoad,
  input wire logic        fixedCall,
  input wire logic [10:0] fixedOffset,
  input wire logic        aluUpdate,
  input wire logic [7:0]  aluResult,
  input wire logic        aluCarry,
  input wire logic        aluHalfCarry,
  input wire logic        pswPush,
  input wire logic        pswPop,
  input wire logic [7:0]  popData,
  input wire logic        intLowLevel,
  input wire logic        intAccept,
  input wire logic [15:0] probeAddr,
  input wire logic [6:0]  probeRegion,
  input wire logic [15:0] programCounter,
  input wire logic [7:0]  processorStatusWord,
  input wire logic [15:0] stackPointer,
  input wire logic [15:0] memAddr,
  input wire logic [7:0]  memWrData
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Register writes override the core, so the pc, flag, push and pop checks only run while the bus is quiet.
  wire logic q = coreReady && !awvalid && !wvalid && !pswPop;
  wire logic [7:0] processor_status_word = processorStatusWord;
  function automatic logic [6:0] rgn(input logic [15:0] a);
    logic ram;
    ram = a >= 16'hfc00 && a <= 16'hfeff;
    return {ram, a >= 16'hff00, a >= 16'hfee0 && a <= 16'hfeff, ram,
            a >= 16'h0800 && a <= 16'h0fff, a == 16'h0080, a >= 16'h0040 && a <= 16'h007f};
  endfunction
  AST_PSW_RST: assert property ($rose(rst_b) |-> processor_status_word == 8'h02)
    else $error("status word not at reset value");
  AST_PC_STEP: assert property (q && pcAdvance && !pcLoad && !fixedCall |=>
    programCounter == $past(programCounter) + 16'($past(pcStep))) else $error("pc step");
  AST_FCALL: assert property (q && fixedCall |=>
    programCounter == {5'h01, $past(fixedOffset)}) else $error("fixed call target");
  AST_FLAGS: assert property (q && aluUpdate |=> {processor_status_word[6], processor_status_word[4], processor_status_word[0]} ==
    {$past(aluResult) == 8'h00, $past(aluHalfCarry), $past(aluCarry)}) else $error("alu flags");
  AST_PUSH: assert property (q && pswPush |=> stackPointer == $past(stackPointer) - 16'h0001
    && memAddr == stackPointer && memWrData == $past(processor_status_word)) else $error("status push");
  AST_POP: assert property (coreReady && !awvalid && !wvalid && pswPop && !pswPush |=>
    processor_status_word == $past(popData) && stackPointer == $past(stackPointer) + 16'h0001) else $error("pop");
  AST_INT_GATE: assert property (!processor_status_word[7] || (!processor_status_word[1] && intLowLevel) |=> !intAccept)
    else $error("interrupt accepted while gated");
  AST_REGION: assert property ($past(rst_b) |-> probeRegion == rgn($past(probeAddr)))
    else $error("address region flags wrong");
  cover property (q && pswPush);
  cover property (intAccept);
  cover property (q && fixedCall);
endmodule
`default_nettype wire

// ==== test/cpu_control_state_bench.sv ====
// Purpose: Directed bench for the control state block.
// Assumes: Reset vector 1234H; memory answers one cycle after memAddr.
// Notes:   Core strobe bits, msb first: advance, load, fixed, table, alu, carry,
//          bank, disable, enable, push, pop, regwrite.
`timescale 1ns/1ps
`default_nettype none
module cpu_control_state_bench;
  import cpu_state_pkg::*;
  logic mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, pcAdvance, pcLoad, fixedCall;
  logic tableCall, aluUpdate, aluCarry, aluHalfCarry, carryWrite, carryValue, bankSelect;
  logic intDisable, intEnable, intRequest, intLowLevel, pswPush, pswPop, regWrite, regPair;
  logic [7:0] awaddr, araddr, aluResult, popData, memRdData, memWrData, processorStatusWord;
  logic [15:0] pcTarget, regWrData, probeAddr, programCounter, stackPointer, memAddr, pc0;
  logic [31:0] wdata, rdata;
  logic [15:0] regRdData;
  logic [11:0] stb;
  logic [10:0] fixedOffset;
  logic [6:0] probeRegion;
  logic [4:0] tableIndex;
  logic [3:0] wstrb;
  logic [2:0] pcStep, regIndex, flg;
  logic [1:0] bankValue, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, coreReady, intAccept, memWrite;
  logic [15:0] pt [10] = '{16'h0040, 16'h007f, 16'h0080, 16'h0800, 16'h0fff, 16'hfc00,
                           16'hfee0, 16'hfeff, 16'hff00, 16'h1000};
  logic [6:0] ex [10] = '{7'h01, 7'h01, 7'h02, 7'h04, 7'h04, 7'h48, 7'h58, 7'h58, 7'h20,
                          7'h00};
  int mismatches, cmp_count, i;
  assign {pcAdvance, pcLoad, fixedCall, tableCall, aluUpdate, carryWrite, bankSelect,
          intDisable, intEnable, pswPush, pswPop, regWrite} = stb;
  assign flg = {processorStatusWord[PSW_Z], processorStatusWord[PSW_AC], processorStatusWord[PSW_CY]};
  cpu_control_state cpu_control_state_inst (.mclk, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pcAdvance, .pcStep, .pcLoad, .pcTarget, .fixedCall, .fixedOffset,
    .tableCall, .tableIndex, .aluUpdate, .aluResult, .aluCarry, .aluHalfCarry, .carryWrite,
    .carryValue, .bankSelect, .bankValue, .intDisable, .intEnable, .intRequest, .intLowLevel,
    .pswPush, .pswPop, .popData, .regWrite, .regPair, .regIndex, .regWrData, .probeAddr,
    .memRdData, .programCounter, .processorStatusWord, .stackPointer, .coreReady, .intAccept,
    .memAddr, .memWrData, .memWrite, .regRdData, .probeRegion);
  // -------------------------------------------------------------
  // Memory, clock and helpers
  // -------------------------------------------------------------
  always @(posedge mclk) memRdData <= memAddr == 16'h0 ? 8'h34 : memAddr == 16'h1 ? 8'h12 : 8'h0;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // On a read, d is the expected data under mask m.
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d, m,
                    input logic [1:0] er);
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, {3{wr}}};
    {araddr, arvalid, rready} <= {a, {2{!wr}}};
    for (int n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        chk(bresp, er);
        return;
      end
      if (rvalid && rready) begin
        rready <= 1'b0;
        chk(rdata & m, d & m);
        chk(rresp, er);
        return;
      end
    end
    mismatches++;
    summarize();
  endtask
  task automatic core(input logic [11:0] s);
    @(posedge mclk);
    stb <= s;
    @(posedge mclk);
    stb <= 12'h000;
    @(negedge mclk);
  endtask
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, aluCarry, aluHalfCarry, carryValue,
     intRequest, intLowLevel, regPair, awaddr, araddr, aluResult, popData, wdata,
     pcTarget, regWrData, probeAddr, pcStep, regIndex, fixedOffset, tableIndex, bankValue} = '0;
    {wstrb, stb} = {4'hf, 12'h000};
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (i = 0; i < 20 && coreReady !== 1'b1; i++) @(negedge mclk);
    chk(programCounter, 16'h1234);
    chk(processorStatusWord, 8'h02);
    ax(0, REG_PSW, 32'h02, 32'hff, RESP_OKAY);
    ax(0, 8'h10, 32'h0, 32'hffffffff, RESP_SLVERR);
    ax(1, REG_SP, 32'hfe00, 32'h0, RESP_OKAY);
    core(12'h004);
    chk(stackPointer, 16'hfdff);
    chk(memWrite, 1'b1);
    chk(memWrData, 8'h02);
    popData <= 8'h81;
    core(12'h002);
    chk({processorStatusWord, stackPointer}, 24'h81fe00);
    {intRequest, intLowLevel} <= 2'b11;
    repeat (4) @(negedge mclk);
    chk(processorStatusWord[PSW_IE], 1'b1);
    intLowLevel <= 1'b0;
    for (i = 0; i < 20 && intAccept !== 1'b1; i++) @(negedge mclk);
    intRequest <= 1'b0;
    chk(intAccept, 1'b1);
    chk({processorStatusWord[PSW_IE], stackPointer}, 17'h0fdff);
    core(12'h008);
    chk(processorStatusWord[PSW_IE], 1'b1);
    core(12'h010);
    chk(processorStatusWord[PSW_IE], 1'b0);
    {aluResult, aluCarry, aluHalfCarry} <= 10'h003;
    core(12'h080);
    chk(flg, 3'b111);
    {aluResult, aluCarry, aluHalfCarry, carryValue} <= 11'h080;
    core(12'h080);
    chk(flg, 3'b000);
    carryValue <= 1'b1;
    core(12'h040);
    chk(flg, 3'b001);
    bankValue <= 2'b01;
    core(12'h020);
    chk({processorStatusWord[PSW_BANK_HI], processorStatusWord[PSW_BANK_LO]}, 2'b01);
    {regIndex, regWrData} <= {3'd3, 16'h005a};
    core(12'h001);
    ax(0, 8'h30, 32'h5a000000, 32'hff000000, RESP_OKAY);
    chk(regRdData, 16'h005a);
    {pcStep, pcTarget, pc0} <= {3'd3, 16'hfc10, programCounter};
    core(12'h800);
    chk(programCounter, pc0 + 16'd3);
    core(12'h400);
    chk(programCounter, pc0 + 16'd3);
    ax(0, REG_STATUS, 32'h8, 32'h8, RESP_OKAY);
    {fixedOffset, tableIndex} <= {11'h7ff, 5'd31};
    core(12'h200);
    chk(programCounter, 16'h0fff);
    core(12'h100);
    chk(memAddr, 16'h007e);
    for (i = 0; i < 10; i++) begin
      @(posedge mclk);
      probeAddr <= pt[i];
      @(posedge mclk);
      @(negedge mclk);
      chk(probeRegion, ex[i]);
    end
    repeat (2) @(posedge mclk);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    summarize();
  end
endmodule
bind cpu_control_state cpu_state_monitor cpu_state_monitor_inst (.mclk, .rst_b, .awvalid,
  .wvalid, .coreReady, .pcAdvance, .pcStep, .pcLoad, .fixedCall, .fixedOffset, .aluUpdate,
  .aluResult, .aluCarry, .aluHalfCarry, .pswPush, .pswPop, .popData, .intLowLevel, .intAccept,
  .probeAddr, .probeRegion, .programCounter, .processorStatusWord, .stackPointer, .memAddr,
  .memWrData);
`default_nettype wire
